//--- src/sdrc_pkg.sv
// Constants, types and helpers for the SDRAM controller control-register block
package sdrc_pkg;

    // Register map
    localparam logic [15:0] MEM_CTL_ONE_OFS = 16'h8400;
    localparam logic [31:0] MEM_CTL_ONE_RST = 32'h248C0040;

    // Field positions in memory_control_one
    localparam int RATIO_HI    = 20;
    localparam int RATIO_LO    = 18;
    localparam int START_BIT   = 17;
    localparam int IVAL_HI     = 16;
    localparam int IVAL_LO     = 8;
    localparam int STAG_HI     = 7;
    localparam int STAG_LO     = 6;
    localparam int SETUP_BIT   = 5;
    localparam int TESTREF_BIT = 4;
    localparam int ARB_BIT     = 3;
    localparam int REMAP_BIT   = 2;
    localparam int MRSPRG_BIT  = 0;

    // Clock ratio
    localparam logic [2:0] RATIO_RESERVED = 3'h0;
    localparam logic [2:0] RATIO_DEFAULT  = 3'h3;
    localparam logic [3:0] HALF_OFFSET    = 4'h3;   // code + 3 = divide ratio in half clocks

    // Refresh
    localparam int          REFRESH_MULT_LOG2 = 6;  // interval scales by 64 core clocks
    localparam int          RCNT_W            = 15;
    localparam logic [14:0] RCNT_ONE          = 15'h0001;

    // Region remap
    localparam logic [22:0] SMM_WIN_BASE = 23'h400000;
    localparam logic [22:0] SMM_WIN_SIZE = 23'h020000;
    localparam logic [19:0] SMM_PHYS_LO  = 20'hA0000;

    // Mode register image: interleaved burst, length two
    localparam logic [5:0] MRS_UPPER  = 6'h00;
    localparam logic       MRS_BT_INT = 1'h1;
    localparam logic [2:0] MRS_BL_TWO = 3'h1;
    localparam int         PRE_ALL_BIT = 10;

    // Sequencer states, Gray along IDLE-SETUP-PRE-GAP
    typedef enum logic [1:0] {
        SDRC_IDLE  = 2'h0,
        SDRC_SETUP = 2'h1,
        SDRC_PRE   = 2'h3,
        SDRC_GAP   = 2'h2
    } sdrc_st_t;

    // Stagger code to SDRAM clocks
    function automatic logic [2:0] sdrc_stagger(input logic [1:0] code);
        unique case (code)
            2'h0:    sdrc_stagger = 3'h0;
            2'h1:    sdrc_stagger = 3'h1;
            2'h2:    sdrc_stagger = 3'h2;
            default: sdrc_stagger = 3'h4;
        endcase
    endfunction

endpackage

//--- src/sdrc_clkdiv.sv
// Fractional divider that makes the SDRAM clock and its rising-edge enable
`timescale 1ns/1ps
`default_nettype none
module sdrc_clkdiv (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic       load,
    input  wire logic [2:0] ratio,
    input  wire logic [2:0] shift,
    // Outputs
    output logic            sd_clk,
    output logic            sd_rise
);
    typedef struct packed {
        logic [3:0] acc;
        logic [1:0] dly;
        logic       clk;
        logic       rise;
    } sdrc_div_t;

    sdrc_div_t s_q, s_d;
    logic [3:0] n2;
    logic [3:0] sum;

    // Half-clock accumulator: x.5 ratios alternate long and short periods
    always_comb begin
        s_d = s_q;
        n2 = {1'b0, ratio} + sdrc_pkg::HALF_OFFSET;
        sum = s_q.acc + 4'h2;
        s_d.rise = 1'b0;
        if (!run) begin
            s_d = '0;
        end else if (load) begin
            // Shift rounds down to whole core clocks: only one clock edge to use
            s_d.acc = 4'h0;
            s_d.dly = shift[2:1];
            s_d.clk = 1'b0;
        end else if (s_q.dly != 2'h0) begin
            s_d.dly = s_q.dly - 2'h1;
        end else begin
            if (sum >= n2) begin
                s_d.acc = sum - n2;
                s_d.rise = 1'b1;
            end else begin
                s_d.acc = sum;
            end
            s_d.clk = ({s_d.acc, 1'b0} < {1'b0, n2});
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sd_clk  = s_q.clk;
    assign sd_rise = s_q.rise;
endmodule
`default_nettype wire

//--- src/sdrc_top.sv
// SDRAM controller first control register with clock, refresh, mode and arbitration logic
`timescale 1ns/1ps
`default_nettype none
module sdrc_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    // Values held in neighbouring registers
    input  wire logic [2:0]  sdram_clock_shift,
    input  wire logic [2:0]  cas_latency_field,
    // Arbitration: [0] hi-pri display, [1] cpu, [2] graphics, [3] display
    input  wire logic [3:0]  arb_req,
    output logic      [3:0]  arb_gnt,
    // Region remap
    input  wire logic [22:0] acc_addr,
    output logic      [19:0] map_addr,
    output logic             map_hit,
    // SDRAM side
    output logic             sdram_clock_output,
    output logic      [3:0]  sdram_cs_n,
    output logic             sdram_ras_n,
    output logic             sdram_cas_n,
    output logic             sdram_we_n,
    output logic      [12:0] sdram_ma
);
    typedef struct packed {
        logic [31:0]       ctl;
        logic [31:0]       rdata;
        logic              rvalid;
        logic [2:0]        ratio_act;
        logic [2:0]        shift_act;
        logic              run;
        logic              load;
        logic [14:0]       rcnt;
        logic              ref_pend;
        logic              mrs_pend;
        sdrc_pkg::sdrc_st_t st;
        logic              tgt_mrs;
        logic [2:0]        gap;
        logic [1:0]        bank;
        logic [3:0]        cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [12:0]       ma;
        logic [3:0]        gnt;
        logic [1:0]        rr;
        logic [19:0]       map_addr;
        logic              map_hit;
    } sdrc_state_t;

    sdrc_state_t s_q, s_d;
    logic        sd_clk;
    logic        sd_rise;
    logic        wr_hit;
    logic        start_rise;
    logic        mrs_rise;
    logic        per_tick;
    logic [8:0]  ival;
    logic [14:0] limit;
    logic [2:0]  stag;
    logic [12:0] mrs_img;
    logic [12:0] pre_img;
    logic [22:0] win_ofs;
    logic [1:0]  idx;
    logic        found;

    sdrc_clkdiv u_div (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .run     (s_q.run),
        .load    (s_q.load),
        .ratio   (s_q.ratio_act),
        .shift   (s_q.shift_act),
        .sd_clk  (sd_clk),
        .sd_rise (sd_rise)
    );

    // Decode, field views and command images
    always_comb begin
        wr_hit     = reg_wr && (reg_addr == sdrc_pkg::MEM_CTL_ONE_OFS);
        start_rise = wr_hit && reg_wdata[sdrc_pkg::START_BIT] && !s_q.ctl[sdrc_pkg::START_BIT];
        mrs_rise   = wr_hit && reg_wdata[sdrc_pkg::MRSPRG_BIT]
                     && !s_q.ctl[sdrc_pkg::MRSPRG_BIT];
        ival       = s_q.ctl[sdrc_pkg::IVAL_HI:sdrc_pkg::IVAL_LO];
        limit      = {ival, {sdrc_pkg::REFRESH_MULT_LOG2{1'b0}}};
        stag       = sdrc_pkg::sdrc_stagger(s_q.ctl[sdrc_pkg::STAG_HI:sdrc_pkg::STAG_LO]);
        per_tick   = (ival != 9'h000) && (s_q.rcnt >= limit - sdrc_pkg::RCNT_ONE);
        mrs_img    = {sdrc_pkg::MRS_UPPER, cas_latency_field, sdrc_pkg::MRS_BT_INT,
                      sdrc_pkg::MRS_BL_TWO};
        pre_img    = 13'h0000;
        pre_img[sdrc_pkg::PRE_ALL_BIT] = 1'b1;
        win_ofs    = acc_addr - sdrc_pkg::SMM_WIN_BASE;
    end

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.load = 1'b0;
        idx = 2'h0;
        found = 1'b0;

        // Register port: reads answer one cycle later, unmapped reads give zero
        s_d.rvalid = reg_rd;
        s_d.rdata  = (reg_rd && reg_addr == sdrc_pkg::MEM_CTL_ONE_OFS) ? s_q.ctl : 32'h0;
        if (wr_hit) begin
            s_d.ctl = reg_wdata;
        end

        // Ratio and shift latch only on a start rising edge; a reserved code keeps
        // the old ratio so the divider never sees code zero, a period of 3 half clocks
        if (start_rise) begin
            if (reg_wdata[sdrc_pkg::RATIO_HI:sdrc_pkg::RATIO_LO] != sdrc_pkg::RATIO_RESERVED) begin
                s_d.ratio_act = reg_wdata[sdrc_pkg::RATIO_HI:sdrc_pkg::RATIO_LO];
            end
            s_d.shift_act = sdram_clock_shift;
            s_d.run  = 1'b1;
            s_d.load = 1'b1;
        end

        // Periodic refresh counter
        if (ival == 9'h000) begin
            s_d.rcnt = 15'h0000;
        end else if (per_tick) begin
            s_d.rcnt = 15'h0000;
        end else begin
            s_d.rcnt = s_q.rcnt + sdrc_pkg::RCNT_ONE;
        end

        // Command sequencer, advances on each SDRAM clock rising edge
        if (sd_rise) begin
            s_d.cs_n  = 4'hF;
            s_d.ras_n = 1'b1;
            s_d.cas_n = 1'b1;
            s_d.we_n  = 1'b1;
            unique case (s_q.st)
                sdrc_pkg::SDRC_IDLE: begin
                    if (s_q.mrs_pend || s_q.ref_pend) begin
                        s_d.tgt_mrs = s_q.mrs_pend;
                        s_d.ma = s_q.mrs_pend ? mrs_img : pre_img;
                        if (s_q.ctl[sdrc_pkg::SETUP_BIT]) begin
                            s_d.st = sdrc_pkg::SDRC_SETUP;
                        end else if (s_q.mrs_pend) begin
                            s_d.cs_n = 4'h0;
                            s_d.ras_n = 1'b0;
                            s_d.cas_n = 1'b0;
                            s_d.we_n = 1'b0;
                            s_d.mrs_pend = 1'b0;
                        end else begin
                            s_d.cs_n = 4'h0;
                            s_d.ras_n = 1'b0;
                            s_d.we_n = 1'b0;
                            s_d.ref_pend = 1'b0;
                            s_d.st = sdrc_pkg::SDRC_PRE;
                        end
                    end
                end
                sdrc_pkg::SDRC_SETUP: begin
                    // Address has stood one clock with chip selects high
                    s_d.cs_n = 4'h0;
                    s_d.ras_n = 1'b0;
                    s_d.we_n = 1'b0;
                    if (s_q.tgt_mrs) begin
                        s_d.cas_n = 1'b0;
                        s_d.mrs_pend = 1'b0;
                        s_d.st = sdrc_pkg::SDRC_IDLE;
                    end else begin
                        s_d.ref_pend = 1'b0;
                        s_d.st = sdrc_pkg::SDRC_PRE;
                    end
                end
                sdrc_pkg::SDRC_PRE, sdrc_pkg::SDRC_GAP: begin
                    if (s_q.st == sdrc_pkg::SDRC_GAP && s_q.gap != 3'h0) begin
                        s_d.gap = s_q.gap - 3'h1;
                    end else begin
                        s_d.ras_n = 1'b0;
                        s_d.cas_n = 1'b0;
                        s_d.gap = stag;
                        if (stag == 3'h0) begin
                            s_d.cs_n = 4'h0;
                            s_d.st = sdrc_pkg::SDRC_IDLE;
                        end else begin
                            s_d.cs_n = ~(4'h1 << (s_q.st == sdrc_pkg::SDRC_PRE ? 2'h0
                                                                               : s_q.bank));
                            s_d.bank = (s_q.st == sdrc_pkg::SDRC_PRE) ? 2'h1
                                                                      : s_q.bank + 2'h1;
                            s_d.st = (s_q.st == sdrc_pkg::SDRC_GAP && s_q.bank == 2'h3)
                                     ? sdrc_pkg::SDRC_IDLE : sdrc_pkg::SDRC_GAP;
                        end
                    end
                end
            endcase
        end

        // New requests win over the clear done above in the same cycle
        if (per_tick || (wr_hit && reg_wdata[sdrc_pkg::TESTREF_BIT])) begin
            s_d.ref_pend = 1'b1;
        end
        if (mrs_rise) begin
            s_d.mrs_pend = 1'b1;
        end

        // Arbitration: high-priority display first, then optional cpu priority,
        // then round robin among cpu, graphics and display from the pointer
        s_d.gnt = 4'h0;
        if (arb_req[0]) begin
            s_d.gnt = 4'h1;
        end else if (s_q.ctl[sdrc_pkg::ARB_BIT] && arb_req[1]) begin
            s_d.gnt = 4'h2;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!found && arb_req[2'((3'(s_q.rr) + 3'(i)) % 3'h3) + 2'h1]) begin
                    found = 1'b1;
                    idx = 2'((3'(s_q.rr) + 3'(i)) % 3'h3);  // 3-bit sum: 2 bits wrap at 4
                end
            end
            if (found) begin
                s_d.gnt = 4'h2 << idx;
                s_d.rr = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
            end
        end

        // Region remap
        s_d.map_hit  = s_q.ctl[sdrc_pkg::REMAP_BIT] && (acc_addr >= sdrc_pkg::SMM_WIN_BASE)
                       && (win_ofs < sdrc_pkg::SMM_WIN_SIZE);
        s_d.map_addr = s_d.map_hit ? sdrc_pkg::SMM_PHYS_LO + win_ofs[19:0] : 20'h00000;
    end

    // State register; only constants under reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.ctl <= sdrc_pkg::MEM_CTL_ONE_RST;
            s_q.ratio_act <= sdrc_pkg::RATIO_DEFAULT;
            s_q.cs_n <= 4'hF;
            s_q.ras_n <= 1'b1;
            s_q.cas_n <= 1'b1;
            s_q.we_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata          = s_q.rdata;
    assign reg_rvalid         = s_q.rvalid;
    assign arb_gnt            = s_q.gnt;
    assign map_addr           = s_q.map_addr;
    assign map_hit            = s_q.map_hit;
    assign sdram_clock_output = sd_clk;
    assign sdram_cs_n         = s_q.cs_n;
    assign sdram_ras_n        = s_q.ras_n;
    assign sdram_cas_n        = s_q.cas_n;
    assign sdram_we_n         = s_q.we_n;
    assign sdram_ma           = s_q.ma;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_plain_wr;
        wr_hit && !start_rise;
    endsequence
    sequence s_mrs_cmd;
        sdram_cs_n == 4'h0 && !sdram_ras_n && !sdram_cas_n && !sdram_we_n;
    endsequence
    sequence s_ref_cmd;
        sdram_cs_n != 4'hF && !sdram_ras_n && !sdram_cas_n && sdram_we_n;
    endsequence

    AST_RATIO_HOLD: assert property (s_plain_wr |=> $stable(s_q.ratio_act))
        else $error("ratio changed without start edge");
    AST_RATIO_APPLY: assert property (start_rise && reg_wdata[20:18] != 3'h0
        |=> s_q.ratio_act == $past(reg_wdata[20:18]) && s_q.load)
        else $error("ratio not applied on start edge");
    AST_NO_REFRESH: assert property (ival == 9'h000 && $stable(ival)
        |-> !per_tick && s_q.rcnt == 15'h0000)
        else $error("refresh tick with zero interval");
    AST_PERIOD: assert property (per_tick && $stable(ival) |=> s_q.rcnt == 15'h0000)
        else $error("refresh counter did not wrap");
    AST_TEST_REF: assert property (wr_hit && reg_wdata[4] |=> s_q.ref_pend)
        else $error("test refresh lost");
    AST_HIPRI: assert property (arb_req[0] |=> arb_gnt == 4'h1)
        else $error("hi-pri display not granted");
    AST_CPU_FIRST: assert property (!arb_req[0] && arb_req[1] && s_q.ctl[3]
        |=> arb_gnt == 4'h2)
        else $error("cpu priority ignored");
    AST_MRS_IMAGE: assert property (s_mrs_cmd |-> sdram_ma[3:0] == 4'h9
        && sdram_ma[12:7] == 6'h00)
        else $error("bad mode register image");
    AST_REF_AFTER_PRE: assert property ((s_ref_cmd
        and ($changed(sdram_cs_n) || $changed(sdram_cas_n)))
        |-> $past(s_q.st) == sdrc_pkg::SDRC_PRE || $past(s_q.st) == sdrc_pkg::SDRC_GAP)
        else $error("refresh without precharge");
    AST_SETUP_IDLE: assert property (s_q.st == sdrc_pkg::SDRC_SETUP |-> sdram_cs_n == 4'hF)
        else $error("chip select during setup clock");
    AST_REMAP: assert property (s_q.ctl[2] && acc_addr == 23'h400000 && !wr_hit
        |=> map_hit && map_addr == 20'hA0000)
        else $error("remap window wrong");
endmodule
`default_nettype wire

//--- bench/sdrc_sdram_model.sv
// Behavioural SDRAM devices that decode and record each command seen at a clock rise
`timescale 1ns/1ps
`default_nettype none
module sdrc_sdram_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // SDRAM pins
    input  wire logic        sdram_clock_output,
    input  wire logic [3:0]  sdram_cs_n,
    input  wire logic        sdram_ras_n,
    input  wire logic        sdram_cas_n,
    input  wire logic        sdram_we_n,
    input  wire logic [12:0] sdram_ma,
    // Observations
    output var int           n_rise,
    output var int           period_sum,
    output var int           n_pre,
    output var int           pre_gap,
    output var int           n_refbank,
    output var int           ref_gap,
    output var int           n_mrs,
    output logic      [12:0] mrs_ma,
    output logic             setup_seen,
    output logic             pre_all
);
    int          cyc, last_rise, last_per, tick, pre_at, ref_at, ref_idx;
    logic        clk_q, idle_q;
    logic [12:0] ma_q;

    // Sample once per SDRAM period; the pair of periods hides half-clock ratios
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_q <= 1'b0;
        end else begin
            cyc   <= cyc + 1;
            clk_q <= sdram_clock_output;
            if (sdram_clock_output && !clk_q) begin
                n_rise     <= n_rise + 1;
                last_rise  <= cyc;
                last_per   <= cyc - last_rise;
                period_sum <= cyc - last_rise + last_per;
                tick       <= tick + 1;
                idle_q     <= &sdram_cs_n;
                ma_q       <= sdram_ma;
                if (!(&sdram_cs_n)) begin
                    case ({sdram_ras_n, sdram_cas_n, sdram_we_n})
                        3'h2: begin  // Precharge opens a new refresh
                            n_pre   <= n_pre + 1;
                            pre_gap <= cyc - pre_at;
                            pre_at  <= cyc;
                            pre_all <= sdram_ma[10];
                            ref_idx <= 0;
                        end
                        3'h1: begin  // Auto refresh, one or more banks
                            n_refbank <= n_refbank + $countones(~sdram_cs_n);
                            if (ref_idx > 0) ref_gap <= tick - ref_at;
                            ref_at  <= tick;
                            ref_idx <= ref_idx + 1;
                        end
                        3'h0: begin  // Mode register set
                            n_mrs      <= n_mrs + 1;
                            mrs_ma     <= sdram_ma;
                            setup_seen <= idle_q && (ma_q === sdram_ma);
                        end
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/tb_sdrc_top.sv
// Self-checking testbench for the SDRAM controller control-register block
`timescale 1ns/1ps
`default_nettype none
module tb_sdrc_top;
    localparam logic [15:0] A = sdrc_pkg::MEM_CTL_ONE_OFS;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic [2:0]  sdram_clock_shift = 3'h0;
    logic [2:0]  cas_latency_field = 3'h0;
    logic [3:0]  arb_req = 4'h0;
    logic [3:0]  arb_gnt;
    logic [22:0] acc_addr = 23'h000000;
    logic [19:0] map_addr;
    logic        map_hit, sdram_clock_output, sdram_ras_n, sdram_cas_n, sdram_we_n;
    logic [3:0]  sdram_cs_n;
    logic [12:0] sdram_ma, mrs_ma;
    logic        setup_seen, pre_all;
    int          n_rise, period_sum, n_pre, pre_gap, n_refbank, ref_gap, n_mrs;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [31:0] cfg = 32'h248C0040;

    // 200 MHz core clock
    always #2.5 clk_sys = ~clk_sys;

    sdrc_top dut (.clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .sdram_clock_shift, .cas_latency_field, .arb_req, .arb_gnt, .acc_addr,
        .map_addr, .map_hit, .sdram_clock_output, .sdram_cs_n, .sdram_ras_n, .sdram_cas_n,
        .sdram_we_n, .sdram_ma);
    sdrc_sdram_model sdram (.clk_sys, .nrst, .sdram_clock_output, .sdram_cs_n, .sdram_ras_n,
        .sdram_cas_n, .sdram_we_n, .sdram_ma, .n_rise, .period_sum, .n_pre, .pre_gap,
        .n_refbank, .ref_gap, .n_mrs, .mrs_ma, .setup_seen, .pre_all);

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every task starts and ends just after a rising edge
    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [31:0] d);
        reg_write(A, d);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            if (reg_rvalid === 1'b1) begin
                chk(what, exp, reg_rdata);
                return;
            end
        end
        chk("read answer", 1, 0);
        give_verdict();
    endtask

    // Bounded wait on a command count of the memory model: 0 precharge, 1 mode set
    task automatic wait_cnt(input int k, input int target, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge clk_sys);
            if ((k == 0 ? n_pre : n_mrs) >= target) return;
        end
        chk("command wait", target, k == 0 ? n_pre : n_mrs);
        give_verdict();
    endtask

    task automatic restart(input logic [2:0] code);
        cfg[20:18] = code;
        cfg[17]    = 1'b0;
        wr(cfg);
        cfg[17] = 1'b1;
        wr(cfg);
        repeat (60) @(posedge clk_sys);
    endtask

    task automatic mrs(input logic setup, input logic [12:0] exp);
        int n;
        n      = n_mrs;
        cfg[5] = setup;
        cfg[0] = 1'b0;
        wr(cfg);
        cfg[0] = 1'b1;
        wr(cfg);
        wait_cnt(1, n + 1, 200);
        repeat (20) @(posedge clk_sys);
        chk("mode image", {19'h0, exp}, mrs_ma);
        chk("address setup tick", {31'h0, setup}, setup_seen);
        chk("mode commands", n + 1, n_mrs);
    endtask

    task automatic arb(input logic prio, input logic [3:0] req, input logic [3:0] exp);
        cfg[3] = prio;
        wr(cfg);
        arb_req <= req;
        repeat (3) @(posedge clk_sys);
        chk("grant", {28'h0, exp}, arb_gnt);
    endtask

    task automatic remap(input logic en, input logic [22:0] a, input logic [20:0] exp);
        cfg[2] = en;
        wr(cfg);
        acc_addr <= a;
        repeat (3) @(posedge clk_sys);
        chk("remap", {11'h0, exp}, {11'h0, map_hit, map_addr});
    endtask

    initial begin
        int p0, b0;
        logic [3:0] g;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        // Register map, an unmapped neighbour and the stopped clock after reset
        rd_chk(A, 32'h248C0040, "reset value");
        reg_write(16'h8404, 32'hFFFFFFFF);
        rd_chk(16'h8404, 32'h00000000, "unmapped read");
        rd_chk(A, 32'h248C0040, "after unmapped write");
        chk("clock idle", 0, n_rise);
        // Every ratio code; pair of periods in core clocks is twice the ratio
        sdram_clock_shift <= 3'h2;
        for (int c = 1; c < 8; c++) begin
            restart(3'(c));
            chk("clock period pair", c + 3, period_sum);
        end
        restart(3'h0);
        chk("reserved ratio", 10, period_sum);
        cfg[20:18] = 3'h1;
        wr(cfg);
        repeat (60) @(posedge clk_sys);
        chk("ratio without start edge", 10, period_sum);
        restart(3'h1);
        chk("ratio after start edge", 4, period_sum);
        // Mode register programming with and without address setup
        cas_latency_field <= 3'h2;
        mrs(1'b0, 13'h0029);
        cas_latency_field <= 3'h5;
        mrs(1'b1, 13'h0059);
        // Interval zero is silent; each test write gives one refresh
        p0 = n_pre;
        b0 = n_refbank;
        repeat (300) @(posedge clk_sys);
        chk("no refresh at zero interval", p0, n_pre);
        cfg[4] = 1'b1;
        wr(cfg);
        repeat (40) @(posedge clk_sys);
        wr(cfg);
        cfg[4] = 1'b0;
        wr(cfg);
        repeat (60) @(posedge clk_sys);
        chk("test refresh count", p0 + 2, n_pre);
        chk("banks refreshed", b0 + 8, n_refbank);
        chk("precharge all", 1, pre_all);
        // Periodic refresh under every stagger code, then a longer interval
        cfg[16:8] = 9'h001;
        for (int s = 0; s < 5; s++) begin
            if (s == 4) cfg[16:8] = 9'h002;
            else cfg[7:6] = 2'(s);
            wr(cfg);
            wait_cnt(0, n_pre + 2, 600);
            repeat (40) @(posedge clk_sys);
            p0 = n_pre;
            b0 = n_refbank;
            wait_cnt(0, p0 + 2, 600);
            repeat (40) @(posedge clk_sys);
            chk("refresh spacing", s == 4 ? 128 : 64, pre_gap);
            chk("banks per refresh", b0 + 8, n_refbank);
            if (s > 0 && s < 4) chk("stagger", s == 3 ? 5 : s + 1, ref_gap);
        end
        cfg[16:8] = 9'h000;
        wr(cfg);
        // Arbitration: high-priority display first, then the selected policy
        arb(1'b0, 4'hF, 4'h1);
        arb(1'b1, 4'hF, 4'h1);
        arb(1'b1, 4'hE, 4'h2);
        arb(1'b0, 4'h8, 4'h8);
        arb_req <= 4'hE;
        @(posedge clk_sys);
        g = 4'h0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            chk("one-hot grant", 1, $countones(arb_gnt));
            g = g | arb_gnt;
        end
        chk("round robin", 32'hE, {28'h0, g});
        arb(1'b0, 4'h4, 4'h4);
        arb_req <= 4'h0;
        // Management window remap at both ends and just past it
        remap(1'b1, 23'h400000, 21'h1A0000);
        remap(1'b1, 23'h41FFFF, 21'h1BFFFF);
        remap(1'b1, 23'h420000, 21'h000000);
        remap(1'b0, 23'h400000, 21'h000000);
        rd_chk(A, cfg, "readback");
        give_verdict();
    end
endmodule
`default_nettype wire
